// [design/drbsp_pkg.sv]
package drbsp_pkg;
  // Widest configuration; narrower parts are built by overriding the parameter.
  localparam int DRBSP_DATA_W = 36;
  // Storage is flip-flops, so the default depth is kept small.
  localparam int DRBSP_ADDR_W = 4;
  localparam int DRBSP_BURST_LEN = 2;
  localparam int DRBSP_NIB_W = 4;
  localparam int DRBSP_BYTE_LANE_W = 9;
  localparam int DRBSP_NWS_W = 2;
  localparam int DRBSP_BWS_W = 4;
  localparam int DRBSP_NIB_DATA_W = 8;
  // Read latency in half cycles of the link clock.
  localparam int DRBSP_RD_LAT_HALF = 5;
  localparam int DRBSP_SYNC_STAGES = 3;
endpackage : drbsp_pkg

// [design/drbsp_port.sv]
`timescale 1ns/1ns
// Contract
// - write words captured on both clock edges
// - read drives stored data onto pins
// - read words launched on both edges
// - drivers high impedance when not reading
// - load strobe sampled on rising edge only
// - every transfer is a two-word burst
// - nibble selects sampled per data word
// - select zero low nibble, one high
// - deselected lane keeps stored data
// - masks sampled with their data word
// - direction high reads, low writes
// - address sampled on rising edge
// - byte selects gate nine-bit lanes
// - valid flag marks read data present
module drbsp_port
  import drbsp_pkg::*;
#(
  parameter int DATA_W = DRBSP_DATA_W,
  parameter int ADDR_W = DRBSP_ADDR_W
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic k_clk_i,
  input wire logic cycle_load_n_i,
  input wire logic rd_not_wr_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] dq_i,
  input wire logic [DRBSP_NWS_W-1:0] nibble_write_sel_n_i,
  input wire logic [DRBSP_BWS_W-1:0] byte_write_sel_n_i,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  output logic read_valid_flag_o,
  output logic rd_taken_o,
  output logic wr_taken_o
);

  localparam int LANE_W = (DATA_W == DRBSP_NIB_DATA_W) ? DRBSP_NIB_W : DRBSP_BYTE_LANE_W;
  localparam int SEL_W = (DATA_W + LANE_W - 1) / LANE_W;
  localparam int DEPTH = 1 << ADDR_W;

  logic [SEL_W-1:0] sel_n;
  logic ld_rd;
  logic ld_wr;
  logic rd_p1_r;
  logic rd_p2_r;
  logic rd_p3_r;
  logic wr_p1_r;
  logic wr_p2_r;
  logic [ADDR_W-1:0] ld_addr_r;
  logic [ADDR_W-1:0] addr2_r;
  logic [ADDR_W-1:0] addr3_r;
  logic w1_vld_r;
  logic [DATA_W-1:0] w1_data_r;
  logic [SEL_W-1:0] w1_sel_n_r;
  logic oe_pos_r;
  logic oe_neg_r;
  logic [DATA_W-1:0] q_pos_r;
  logic [DATA_W-1:0] q_neg_r;
  logic [DATA_W-1:0] mem0 [DEPTH];
  logic [DATA_W-1:0] mem1 [DEPTH];
  logic rd_tgl_r;
  logic wr_tgl_r;
  logic [DRBSP_SYNC_STAGES-1:0] rd_sync_r;
  logic [DRBSP_SYNC_STAGES-1:0] wr_sync_r;

  // The eight-bit part uses nibble selects, all others use byte selects.
  generate
    if (DATA_W == DRBSP_NIB_DATA_W) begin : g_nib
      assign sel_n = nibble_write_sel_n_i[SEL_W-1:0];
    end else begin : g_byte
      assign sel_n = byte_write_sel_n_i[SEL_W-1:0];
    end
  endgenerate

  // Each select covers one lane; a high select keeps the stored lane.
  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old_w,
    input logic [DATA_W-1:0] new_w,
    input logic [SEL_W-1:0] s_n
  );
    logic [DATA_W-1:0] m;
    m = old_w;
    for (int i = 0; i < DATA_W; i++) begin
      if (!s_n[i / LANE_W]) begin
        m[i] = new_w[i];
      end
    end
    return m;
  endfunction : merge

  assign ld_rd = !cycle_load_n_i && rd_not_wr_i;
  assign ld_wr = !cycle_load_n_i && !rd_not_wr_i;

  // Command pipeline on the rising edge of the positive link clock.
  always_ff @(posedge k_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_p1_r <= 1'b0;
      rd_p2_r <= 1'b0;
      rd_p3_r <= 1'b0;
      wr_p1_r <= 1'b0;
      wr_p2_r <= 1'b0;
      oe_pos_r <= 1'b0;
    end else begin
      rd_p1_r <= ld_rd;
      rd_p2_r <= rd_p1_r;
      // The third stage puts the first word in the low half after two full cycles.
      rd_p3_r <= rd_p2_r;
      wr_p1_r <= ld_wr;
      wr_p2_r <= wr_p1_r;
      oe_pos_r <= rd_p3_r;
    end
  end

  // The address is held only when a load is seen, so a high strobe ignores it.
  always_ff @(posedge k_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ld_addr_r <= '0;
      addr2_r <= '0;
      addr3_r <= '0;
    end else begin
      if (!cycle_load_n_i) begin
        ld_addr_r <= addr_i;
      end
      addr2_r <= ld_addr_r;
      addr3_r <= addr2_r;
    end
  end

  // Two arrays, one per burst word, so each sees at most one write per edge.
  always_ff @(posedge k_clk_i) begin
    if (wr_p1_r) begin
      mem0[ld_addr_r] <= merge(mem0[ld_addr_r], dq_i, sel_n);
    end
    if (w1_vld_r) begin
      mem1[addr2_r] <= merge(mem1[addr2_r], w1_data_r, w1_sel_n_r);
    end
    q_pos_r <= mem1[addr3_r];
  end

  // Falling edge of the positive clock stands for the rising edge of its complement.
  always_ff @(negedge k_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      w1_vld_r <= 1'b0;
      oe_neg_r <= 1'b0;
    end else begin
      w1_vld_r <= wr_p2_r;
      oe_neg_r <= rd_p3_r;
    end
  end

  always_ff @(negedge k_clk_i) begin
    w1_data_r <= dq_i;
    w1_sel_n_r <= sel_n;
    q_neg_r <= mem0[addr3_r];
  end

  // Word one shows while the clock is low, word two while it is high.
  assign dq_o = k_clk_i ? q_pos_r : q_neg_r;
  assign dq_oe_o = k_clk_i ? oe_pos_r : oe_neg_r;
  assign read_valid_flag_o = dq_oe_o;

  // Each accepted command flips a toggle that is carried into the system clock.
  always_ff @(posedge k_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_tgl_r <= 1'b0;
      wr_tgl_r <= 1'b0;
    end else begin
      rd_tgl_r <= rd_tgl_r ^ ld_rd;
      wr_tgl_r <= wr_tgl_r ^ ld_wr;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_sync_r <= '0;
      wr_sync_r <= '0;
    end else begin
      rd_sync_r <= {rd_sync_r[DRBSP_SYNC_STAGES-2:0], rd_tgl_r};
      wr_sync_r <= {wr_sync_r[DRBSP_SYNC_STAGES-2:0], wr_tgl_r};
    end
  end

  assign rd_taken_o = rd_sync_r[2] ^ rd_sync_r[1];
  assign wr_taken_o = wr_sync_r[2] ^ wr_sync_r[1];

  // Checks run on the rising link edge unless a property names its own clock.
  default clocking cb_k @(posedge k_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  property p_rd_latency;
    ld_rd |=> rd_p1_r ##1 rd_p2_r ##1 rd_p3_r ##1 oe_pos_r;
  endproperty
  a_rd_latency: assert property (p_rd_latency) else $error("read data not on time");

  property p_burst_two;
    (oe_neg_r && !rd_p2_r) |=> oe_pos_r ##1 !oe_pos_r;
  endproperty
  a_burst_two: assert property (p_burst_two) else $error("read burst not two words");

  property p_load_high;
    cycle_load_n_i |=> !rd_p1_r && !wr_p1_r && $stable(ld_addr_r);
  endproperty
  a_load_high: assert property (p_load_high) else $error("idle strobe started a cycle");

  property p_direction;
    ld_wr |=> wr_p1_r && !rd_p1_r;
  endproperty
  a_direction: assert property (p_direction) else $error("write taken as read");

  property p_addr;
    ld_rd |=> ##1 addr2_r == $past(addr_i, 2);
  endproperty
  a_addr: assert property (p_addr) else $error("address not held");

  property p_mask_keep;
    (wr_p1_r && (&sel_n)) |=> mem0[$past(ld_addr_r)] == $past(mem0[ld_addr_r]);
  endproperty
  a_mask_keep: assert property (p_mask_keep) else $error("masked lane written");

  property p_word_write;
    (wr_p1_r && sel_n == '0) |=> mem0[$past(ld_addr_r)] == $past(dq_i);
  endproperty
  a_word_write: assert property (p_word_write) else $error("write word not stored");

  property p_read_word;
    rd_p3_r |=> q_pos_r == $past(mem1[addr3_r]) && oe_pos_r;
  endproperty
  a_read_word: assert property (p_read_word) else $error("second read word wrong");

  property p_idle_hiz;
    (!rd_p1_r && !rd_p2_r && !rd_p3_r) |=> !oe_pos_r ##1 !oe_neg_r;
  endproperty
  a_idle_hiz: assert property (p_idle_hiz) else $error("driving without a read");

  property p_oe_start;
    ld_rd |-> ##3 dq_oe_o;
  endproperty
  a_oe_start: assert property (p_oe_start) else $error("first read word late");

  property p_rd_addr;
    rd_p3_r |-> addr3_r == $past(addr_i, 3);
  endproperty
  a_rd_addr: assert property (p_rd_addr) else $error("read address lost");

  property p_wr_addr;
    wr_p1_r |-> ld_addr_r == $past(addr_i);
  endproperty
  a_wr_addr: assert property (p_wr_addr) else $error("write address lost");

  property p_neg_word;
    @(negedge k_clk_i) rd_p3_r |=> oe_neg_r && q_neg_r == $past(mem0[addr3_r]);
  endproperty
  a_neg_word: assert property (p_neg_word) else $error("first read word wrong");

  property p_valid_flag;
    @(negedge k_clk_i) rd_p3_r |=> read_valid_flag_o;
  endproperty
  a_valid_flag: assert property (p_valid_flag) else $error("valid flag missing");

  property p_word_two;
    (w1_vld_r && w1_sel_n_r == '0) |=> mem1[$past(addr2_r)] == $past(w1_data_r);
  endproperty
  a_word_two: assert property (p_word_two) else $error("second write word lost");

  property p_keep_two;
    (w1_vld_r && (&w1_sel_n_r)) |=> mem1[$past(addr2_r)] == $past(mem1[addr2_r]);
  endproperty
  a_keep_two: assert property (p_keep_two) else $error("masked lane changed");

  property p_wr_burst;
    ld_wr |=> wr_p1_r ##1 (wr_p2_r && w1_vld_r);
  endproperty
  a_wr_burst: assert property (p_wr_burst) else $error("write burst not two words");

  property p_rd_dir;
    ld_rd |=> rd_p1_r && !wr_p1_r;
  endproperty
  a_rd_dir: assert property (p_rd_dir) else $error("read taken as write");

  property p_idle_neg;
    @(negedge k_clk_i) (!rd_p2_r && !rd_p3_r) |=> !oe_neg_r;
  endproperty
  a_idle_neg: assert property (p_idle_neg) else $error("low half driven idle");

  property p_rd_stream;
    (rd_p3_r && rd_p2_r) |=> oe_pos_r ##1 oe_pos_r;
  endproperty
  a_rd_stream: assert property (p_rd_stream) else $error("back to back reads broken");

  property p_low_lane;
    (wr_p1_r && !sel_n[0]) |=> mem0[$past(ld_addr_r)][LANE_W-1:0] == $past(dq_i[LANE_W-1:0]);
  endproperty
  a_low_lane: assert property (p_low_lane) else $error("low lane not written");

endmodule : drbsp_port

// [testbench/drbsp_ctl_model.sv]
`timescale 1ns/1ns
module drbsp_ctl_model (
  input wire logic k_clk_i,
  input wire logic [7:0] q_i,
  input wire logic q_oe_i,
  output logic cycle_load_n_o,
  output logic rd_not_wr_o,
  output logic [3:0] addr_o,
  output logic [7:0] d_o,
  output logic [1:0] nibble_write_sel_n_o
);
  initial begin
    cycle_load_n_o = 1'b1;
    rd_not_wr_o = 1'b0;
    addr_o = 4'h0;
    d_o = 8'h00;
    nibble_write_sel_n_o = 2'b11;
  end
  task automatic load(input logic rd, input logic [3:0] a);
    @(negedge k_clk_i);
    cycle_load_n_o <= 1'b0;
    rd_not_wr_o <= rd;
    addr_o <= a;
    @(negedge k_clk_i);
    cycle_load_n_o <= 1'b1;
    addr_o <= ~a;
  endtask : load
  task automatic wr(input logic [3:0] a, input logic [15:0] w, input logic [3:0] s);
    load(1'b0, a);
    d_o <= w[15:8];
    nibble_write_sel_n_o <= s[3:2];
    @(posedge k_clk_i);
    d_o <= w[7:0];
    nibble_write_sel_n_o <= s[1:0];
    @(negedge k_clk_i);
    d_o <= ~w[7:0];
    nibble_write_sel_n_o <= 2'b11;
    repeat (2) @(posedge k_clk_i);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] w, output logic [3:0] s);
    load(1'b1, a);
    repeat (2) @(posedge k_clk_i);
    #1 s[3] = q_oe_i;
    @(negedge k_clk_i);
    #1 w[15:8] = q_i;
    s[2] = q_oe_i;
    @(posedge k_clk_i);
    #1 w[7:0] = q_i;
    s[1] = q_oe_i;
    @(negedge k_clk_i);
    #1 s[0] = q_oe_i;
    repeat (2) @(posedge k_clk_i);
  endtask : rd
  task automatic idle(output logic seen);
    seen = 1'b0;
    @(negedge k_clk_i);
    rd_not_wr_o <= 1'b1;
    addr_o <= 4'h3;
    repeat (12) begin
      @(k_clk_i);
      #1 seen |= q_oe_i;
    end
  endtask : idle
endmodule : drbsp_ctl_model

// [testbench/testbench.sv]
`timescale 1ns/1ns
module testbench;
  logic mclk_i = 1'b0;
  logic k_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic ld_n, rd, oe, vld, rd_tk, wr_tk, seen;
  logic [3:0] addr, st;
  logic [7:0] d, q;
  logic [1:0] nibble_write_sel_n;
  logic [15:0] w;
  int err_count = 0;
  int comparisons = 0;
  int n_rd = 0;
  int n_wr = 0;
  initial forever #4 mclk_i = ~mclk_i;
  initial begin
    #1;
    forever #3 k_clk_i = ~k_clk_i;
  end
  always @(negedge mclk_i) begin
    if (rd_tk === 1'b1) n_rd++;
    if (wr_tk === 1'b1) n_wr++;
  end
  drbsp_port #(.DATA_W(8), .ADDR_W(4)) drbsp_port_inst (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .k_clk_i(k_clk_i), .cycle_load_n_i(ld_n), .rd_not_wr_i(rd), .addr_i(addr), .dq_i(d),
    .nibble_write_sel_n_i(nibble_write_sel_n), .byte_write_sel_n_i(4'hf), .dq_o(q), .dq_oe_o(oe),
    .read_valid_flag_o(vld), .rd_taken_o(rd_tk), .wr_taken_o(wr_tk));
  drbsp_ctl_model drbsp_ctl_model_inst (.k_clk_i(k_clk_i), .q_i(q), .q_oe_i(vld & oe),
    .cycle_load_n_o(ld_n), .rd_not_wr_o(rd), .addr_o(addr), .d_o(d),
    .nibble_write_sel_n_o(nibble_write_sel_n));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("errors=%0d comparisons=%0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  task automatic t_full();
    drbsp_ctl_model_inst.wr(4'h3, 16'ha53c, 4'h0);
    drbsp_ctl_model_inst.rd(4'h3, w, st);
    chk(w, 16'ha53c);
    chk({12'h000, st}, 16'h0006);
  endtask : t_full
  task automatic t_nibble();
    drbsp_ctl_model_inst.wr(4'h3, 16'h129f, 4'h9);
    drbsp_ctl_model_inst.rd(4'h3, w, st);
    chk(w, 16'ha29c);
    drbsp_ctl_model_inst.wr(4'h3, 16'hffff, 4'hf);
    drbsp_ctl_model_inst.rd(4'h3, w, st);
    chk(w, 16'ha29c);
  endtask : t_nibble
  task automatic t_idle();
    drbsp_ctl_model_inst.idle(seen);
    chk({15'h0000, seen}, 16'h0000);
    repeat (4) @(posedge mclk_i);
    chk(n_rd[15:0], 16'h0003);
    chk(n_wr[15:0], 16'h0003);
  endtask : t_idle
  initial begin
    repeat (20) @(negedge mclk_i);
    arst_n_i = 1'b1;
    t_full();
    t_nibble();
    t_idle();
    summarize();
  end
  initial begin
    #20000;
    err_count++;
    summarize();
  end
endmodule : testbench
